// ==== rtl/ctar_params.svh ====
// constants for core timing and access routing
// Notes on behaviour
// - single store: two cycles to bus or control space, one to single-cycle port
// - store-multiple, plain push and plain pop take one plus N cycles
// - push with link_reg takes 1+N; pop loading program_counter takes 3+N
// - conditional branch: two cycles when taken, one when it falls through
// - branch two, branch_with_link three, branch_exchange and branch_link_exchange two
// - byte and halfword sign and zero extends execute in one cycle
// - all three byte reversal forms execute in one cycle
// - supervisor_call and breakpoint_instr cycles are configuration parameters
// - wait_event and wait_interrupt take two cycles, excluding idle wait
// - bus matrix arbitrates core and debug_access_port to all targets
// - core always wins over the debug_access_port on contention
// - debug accesses use only cycles the core leaves free
// - debugger and core accesses decode through the same address map
// - addresses outside the private region go to the bus master port
// - private region accesses stay inside and never reach the bus port
// - build option redirects data accesses for the bus to the single-cycle port
// - only word accesses allowed in the private region
// - fetch outside code regions raises hard_fault_exception
// - enabled protection_unit overrides map except for the private region
`ifndef CTAR_PARAMS_SVH
`define CTAR_PARAMS_SVH

// ======================================================================
// address map
`define CTAR_PRIV_BASE 32'he0000000
`define CTAR_PRIV_LAST 32'hefffffff
`define CTAR_CODE_LO_LAST 32'h3fffffff
`define CTAR_CODE_HI_BASE 32'h60000000
`define CTAR_CODE_HI_LAST 32'h9fffffff

// ======================================================================
// instruction cycle figures
`define CTAR_CYC_STORE_BUS 6'h02
`define CTAR_CYC_STORE_IO 6'h01
`define CTAR_CYC_MULTI_BASE 6'h01
`define CTAR_CYC_POP_PC_BASE 6'h03
`define CTAR_CYC_BR_TAKEN 6'h02
`define CTAR_CYC_BR_FALL 6'h01
`define CTAR_CYC_BRANCH 6'h02
`define CTAR_CYC_BRANCH_LINK 6'h03
`define CTAR_CYC_BRANCH_EXCH 6'h02
`define CTAR_CYC_SINGLE 6'h01
`define CTAR_CYC_WAIT 6'h02
`define CTAR_CYC_SPECIAL 6'h03
`define CTAR_CYC_BARRIER 6'h03
`define CTAR_CYC_LAST 6'h01

// ======================================================================
// bus encodings
`define CTAR_HTRANS_IDLE 2'h0
`define CTAR_HTRANS_NONSEQ 2'h2

`endif

// ==== rtl/ctar_pkg.sv ====
// types for core timing and access routing
package ctar_pkg;

	// instruction timing classes
	typedef enum logic [4:0]
	{
		CTAR_OP_ALU = 5'h00,
		CTAR_OP_STORE_SINGLE = 5'h01,
		CTAR_OP_STORE_MULTIPLE = 5'h02,
		CTAR_OP_PUSH = 5'h03,
		CTAR_OP_PUSH_LINK_REG = 5'h04,
		CTAR_OP_POP = 5'h05,
		CTAR_OP_POP_PROGRAM_COUNTER = 5'h06,
		CTAR_OP_BRANCH_COND = 5'h07,
		CTAR_OP_BRANCH = 5'h08,
		CTAR_OP_BRANCH_WITH_LINK = 5'h09,
		CTAR_OP_BRANCH_EXCHANGE = 5'h0a,
		CTAR_OP_BRANCH_LINK_EXCHANGE = 5'h0b,
		CTAR_OP_EXTEND = 5'h0c,
		CTAR_OP_REVERSE = 5'h0d,
		CTAR_OP_SUPERVISOR_CALL = 5'h0e,
		CTAR_OP_BREAKPOINT_INSTR = 5'h0f,
		CTAR_OP_SPECIAL_REG_READ = 5'h10,
		CTAR_OP_SPECIAL_REG_WRITE = 5'h11,
		CTAR_OP_BARRIER = 5'h12,
		CTAR_OP_WAIT_EVENT = 5'h13,
		CTAR_OP_WAIT_INTERRUPT = 5'h14,
		CTAR_OP_SEND_EVENT = 5'h15,
		CTAR_OP_IRQ_TOGGLE = 5'h16,
		CTAR_OP_NOP = 5'h17,
		CTAR_OP_YIELD = 5'h18
	} ctar_op_e;

	// access size, as the low bits of a bus size field
	typedef enum logic [1:0]
	{
		CTAR_SZ_BYTE = 2'h0,
		CTAR_SZ_HALF = 2'h1,
		CTAR_SZ_WORD = 2'h2
	} ctar_size_e;

	// timing sequencer states
	typedef enum logic [2:0]
	{
		CTAR_ST_IDLE = 3'b001,
		CTAR_ST_EXEC = 3'b010,
		CTAR_ST_SLEEP = 3'b100
	} ctar_state_e;

endpackage

// ==== rtl/ctar_route_if.sv ====
// address decode request and verdict between the matrix and its decoder
`timescale 1ns/100ps
interface ctar_route_if;
	import ctar_pkg::*;
	logic [31:0] addr;
	ctar_size_e size;
	logic fetch;
	logic prot_en;
	logic prot_xn;
	logic to_priv;
	logic to_io;
	logic to_ahb;
	logic exec_ok;
	logic size_ok;

	modport decoder (input addr, input size, input fetch, input prot_en, input prot_xn,
		output to_priv, output to_io, output to_ahb, output exec_ok, output size_ok);
	modport user (output addr, output size, output fetch, output prot_en, output prot_xn,
		input to_priv, input to_io, input to_ahb, input exec_ok, input size_ok);
endinterface

// ==== rtl/ctar_route_decode.sv ====
// address map decoder shared by core and debug traffic
`timescale 1ns/100ps
`include "ctar_params.svh"
module ctar_route_decode #(
	parameter bit IO_REDIRECT = 1'b0
)(
	ctar_route_if.decoder rif
);
	import ctar_pkg::*;

	wire in_priv;
	wire code_ok;

	// ======================================================================
	// region decode
	assign in_priv = (rif.addr >= `CTAR_PRIV_BASE) && (rif.addr <= `CTAR_PRIV_LAST);
	assign code_ok = (rif.addr <= `CTAR_CODE_LO_LAST) ||
		((rif.addr >= `CTAR_CODE_HI_BASE) && (rif.addr <= `CTAR_CODE_HI_LAST));

	// ======================================================================
	// verdicts; private region is never opened up by the protection unit
	assign rif.to_priv = in_priv;
	assign rif.to_io = !in_priv && IO_REDIRECT && !rif.fetch;
	assign rif.to_ahb = !in_priv && !rif.to_io;
	assign rif.exec_ok = in_priv ? 1'b0 : (rif.prot_en ? !rif.prot_xn : code_ok);
	assign rif.size_ok = !in_priv || (rif.size == CTAR_SZ_WORD);
endmodule

// ==== rtl/ctar_core_timing.sv ====
// instruction cycle sequencer and bus matrix with address routing
`timescale 1ns/100ps
`include "ctar_params.svh"
module ctar_core_timing #(
	parameter bit IO_REDIRECT = 1'b0,
	parameter int CNT_W = 6,
	parameter int REG_W = 4,
	parameter logic [5:0] SVC_CYCLES = 6'h04,
	parameter logic [5:0] BREAKPOINT_INSTR_CYCLES = 6'h04
)(
	input wire logic i_clock,
	input wire logic i_reset_n,
	// instruction issue side
	input wire logic i_issue,
	input wire ctar_pkg::ctar_op_e i_op,
	input wire logic [REG_W-1:0] i_reg_count,
	input wire logic i_cond_pass,
	input wire logic [31:0] i_store_addr,
	input wire logic i_wake,
	output logic o_issue_ready,
	output logic o_busy,
	output logic o_retire,
	output logic o_sleeping,
	output logic [CNT_W-1:0] o_last_cycles,
	// core master
	input wire logic i_core_req,
	input wire logic [31:0] i_core_addr,
	input wire logic i_core_write,
	input wire ctar_pkg::ctar_size_e i_core_size,
	input wire logic i_core_fetch,
	input wire logic [31:0] i_core_wdata,
	input wire logic i_prot_en,
	input wire logic i_prot_xn,
	output logic o_core_ready,
	output logic o_core_ack,
	// debug master
	input wire logic i_dbg_req,
	input wire logic [31:0] i_dbg_addr,
	input wire logic i_dbg_write,
	input wire ctar_pkg::ctar_size_e i_dbg_size,
	input wire logic [31:0] i_dbg_wdata,
	output logic o_dbg_ready,
	output logic o_dbg_ack,
	// bus master port
	input wire logic i_hready,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata,
	// single-cycle port and private region
	output logic o_io_sel,
	output logic o_priv_sel,
	output logic [31:0] o_local_addr,
	output logic o_local_write,
	output logic [31:0] o_local_wdata,
	// faults
	output logic o_size_fault,
	output logic o_hard_fault
);
	import ctar_pkg::*;

	// ======================================================================
	// cycle lookup
	// one table for every timing class; illegal op codes count as one cycle
	function automatic logic [CNT_W-1:0] op_cycles(
		input ctar_op_e op,
		input logic [REG_W-1:0] n,
		input logic pass,
		input logic io
	);
		logic [CNT_W-1:0] nn;
		logic [CNT_W-1:0] c;
		nn = CNT_W'(n);
		c = CNT_W'(`CTAR_CYC_SINGLE);
		case (op)
			CTAR_OP_STORE_SINGLE:
				c = io ? CNT_W'(`CTAR_CYC_STORE_IO) : CNT_W'(`CTAR_CYC_STORE_BUS);
			CTAR_OP_STORE_MULTIPLE, CTAR_OP_PUSH, CTAR_OP_POP:
				c = CNT_W'(`CTAR_CYC_MULTI_BASE) + nn;
			CTAR_OP_PUSH_LINK_REG:
				c = CNT_W'(`CTAR_CYC_MULTI_BASE) + nn;
			CTAR_OP_POP_PROGRAM_COUNTER:
				c = CNT_W'(`CTAR_CYC_POP_PC_BASE) + nn;
			CTAR_OP_BRANCH_COND:
				c = pass ? CNT_W'(`CTAR_CYC_BR_TAKEN) : CNT_W'(`CTAR_CYC_BR_FALL);
			CTAR_OP_BRANCH:
				c = CNT_W'(`CTAR_CYC_BRANCH);
			CTAR_OP_BRANCH_WITH_LINK:
				c = CNT_W'(`CTAR_CYC_BRANCH_LINK);
			CTAR_OP_BRANCH_EXCHANGE, CTAR_OP_BRANCH_LINK_EXCHANGE:
				c = CNT_W'(`CTAR_CYC_BRANCH_EXCH);
			CTAR_OP_EXTEND:
				c = CNT_W'(`CTAR_CYC_SINGLE);
			CTAR_OP_REVERSE:
				c = CNT_W'(`CTAR_CYC_SINGLE);
			CTAR_OP_SUPERVISOR_CALL:
				c = CNT_W'(SVC_CYCLES);
			CTAR_OP_BREAKPOINT_INSTR:
				c = CNT_W'(BREAKPOINT_INSTR_CYCLES);
			CTAR_OP_WAIT_EVENT, CTAR_OP_WAIT_INTERRUPT:
				c = CNT_W'(`CTAR_CYC_WAIT);
			CTAR_OP_SPECIAL_REG_READ, CTAR_OP_SPECIAL_REG_WRITE:
				c = CNT_W'(`CTAR_CYC_SPECIAL);
			CTAR_OP_BARRIER:
				c = CNT_W'(`CTAR_CYC_BARRIER);
			CTAR_OP_SEND_EVENT, CTAR_OP_IRQ_TOGGLE, CTAR_OP_NOP, CTAR_OP_YIELD:
				c = CNT_W'(`CTAR_CYC_SINGLE);
			default:
				c = CNT_W'(`CTAR_CYC_SINGLE);
		endcase
		// a zero figure would wrap the countdown and stretch the op to 2^CNT_W cycles
		if (c == '0)
		begin
			c = CNT_W'(`CTAR_CYC_LAST);
		end
		return c;
	endfunction

	// ======================================================================
	// store target decode, same map as the bus matrix
	ctar_route_if store_rif ();

	assign store_rif.addr = i_store_addr;
	assign store_rif.size = CTAR_SZ_WORD;
	assign store_rif.fetch = 1'b0;
	assign store_rif.prot_en = 1'b0;
	assign store_rif.prot_xn = 1'b0;

	ctar_route_decode #(
		.IO_REDIRECT(IO_REDIRECT)
	) u_store_decode (
		.rif(store_rif)
	);

	// ======================================================================
	// timing sequencer
	ctar_state_e state;
	ctar_state_e next_state;
	logic [CNT_W-1:0] remain;
	logic [CNT_W-1:0] next_remain;
	logic wait_pend;
	wire issue_take;
	wire issue_is_wait;
	wire last_cycle;
	wire [CNT_W-1:0] issue_cycles;

	assign issue_take = i_issue && o_issue_ready;
	assign issue_is_wait = (i_op == CTAR_OP_WAIT_EVENT) || (i_op == CTAR_OP_WAIT_INTERRUPT);
	assign issue_cycles = op_cycles(i_op, i_reg_count, i_cond_pass, store_rif.to_io);
	assign last_cycle = (state == CTAR_ST_EXEC) && (remain == CNT_W'(`CTAR_CYC_LAST));

	// next state; idle time asleep is not part of the wait figure
	always_comb
	begin
		next_state = state;
		next_remain = remain;
		unique case (state)
			CTAR_ST_IDLE:
			begin
				if (issue_take)
				begin
					next_state = CTAR_ST_EXEC;
					next_remain = issue_cycles;
				end
			end
			CTAR_ST_EXEC:
			begin
				if (last_cycle)
				begin
					next_state = wait_pend ? CTAR_ST_SLEEP : CTAR_ST_IDLE;
				end
				else
				begin
					next_remain = remain - CNT_W'(`CTAR_CYC_LAST);
				end
			end
			CTAR_ST_SLEEP:
			begin
				if (i_wake)
				begin
					next_state = CTAR_ST_IDLE;
				end
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state <= CTAR_ST_IDLE;
			remain <= '0;
			wait_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			remain <= next_remain;
			if (issue_take)
			begin
				wait_pend <= issue_is_wait;
			end
		end
	end

	// sequencer outputs, all registered; ready, busy and sleeping from the next state, retire from the current last cycle
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_issue_ready <= 1'b1;
			o_busy <= 1'b0;
			o_retire <= 1'b0;
			o_sleeping <= 1'b0;
			o_last_cycles <= '0;
		end
		else
		begin
			o_issue_ready <= (next_state == CTAR_ST_IDLE);
			o_busy <= (next_state == CTAR_ST_EXEC);
			o_retire <= last_cycle;
			o_sleeping <= (next_state == CTAR_ST_SLEEP);
			if (issue_take)
			begin
				o_last_cycles <= issue_cycles;
			end
		end
	end

	// ======================================================================
	// bus matrix arbitration
	// core wins any tie, so debug only takes cycles the core leaves free
	wire core_take;
	wire dbg_take;
	wire any_take;

	assign core_take = i_core_req && o_core_ready && i_hready;
	assign dbg_take = i_dbg_req && o_dbg_ready && i_hready && !core_take;
	assign any_take = core_take || dbg_take;

	// ======================================================================
	// shared decode of the winning request
	ctar_route_if bus_rif ();
	wire [31:0] sel_wdata;
	wire sel_write;
	wire issue_ok;

	assign bus_rif.addr = core_take ? i_core_addr : i_dbg_addr;
	assign bus_rif.size = core_take ? i_core_size : i_dbg_size;
	assign bus_rif.fetch = core_take && i_core_fetch;
	assign bus_rif.prot_en = i_prot_en;
	assign bus_rif.prot_xn = i_prot_xn;
	assign sel_wdata = core_take ? i_core_wdata : i_dbg_wdata;
	assign sel_write = core_take ? i_core_write : i_dbg_write;

	ctar_route_decode #(
		.IO_REDIRECT(IO_REDIRECT)
	) u_bus_decode (
		.rif(bus_rif)
	);

	// faulted requests are answered but never reach any target
	assign issue_ok = any_take && bus_rif.size_ok && (!bus_rif.fetch || bus_rif.exec_ok);

	// handshakes: ready drops for one cycle after each take
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_core_ready <= 1'b1;
			o_dbg_ready <= 1'b1;
			o_core_ack <= 1'b0;
			o_dbg_ack <= 1'b0;
			o_size_fault <= 1'b0;
			o_hard_fault <= 1'b0;
		end
		else
		begin
			o_core_ready <= !core_take;
			o_dbg_ready <= !dbg_take;
			o_core_ack <= core_take;
			o_dbg_ack <= dbg_take;
			o_size_fault <= any_take && !bus_rif.size_ok;
			o_hard_fault <= any_take && bus_rif.fetch && !bus_rif.exec_ok;
		end
	end

	// ======================================================================
	// bus master port: address phase, then data phase on the next ready
	logic [31:0] pend_wdata;

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_haddr <= '0;
			o_htrans <= `CTAR_HTRANS_IDLE;
			o_hwrite <= 1'b0;
			o_hsize <= '0;
			o_hwdata <= '0;
			pend_wdata <= '0;
		end
		else if (i_hready)
		begin
			o_hwdata <= pend_wdata;
			if (issue_ok && bus_rif.to_ahb)
			begin
				o_haddr <= bus_rif.addr;
				o_htrans <= `CTAR_HTRANS_NONSEQ;
				o_hwrite <= sel_write;
				o_hsize <= {1'b0, bus_rif.size};
				pend_wdata <= sel_wdata;
			end
			else
			begin
				o_htrans <= `CTAR_HTRANS_IDLE;
			end
		end
	end

	// ======================================================================
	// single-cycle port and private region strobes
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_io_sel <= 1'b0;
			o_priv_sel <= 1'b0;
			o_local_addr <= '0;
			o_local_write <= 1'b0;
			o_local_wdata <= '0;
		end
		else
		begin
			o_io_sel <= issue_ok && bus_rif.to_io;
			o_priv_sel <= issue_ok && bus_rif.to_priv;
			if (issue_ok && !bus_rif.to_ahb)
			begin
				o_local_addr <= bus_rif.addr;
				o_local_write <= sel_write;
				o_local_wdata <= sel_wdata;
			end
		end
	end

endmodule

// ==== testbench/ctar_core_timing_properties.sv ====
// checker for routing and cycle timing of the core timing block
`timescale 1ns/100ps
module ctar_core_timing_checker
	import ctar_pkg::*;
	#(parameter bit IO_REDIRECT = 1'b0)
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_issue,
	input wire ctar_pkg::ctar_op_e i_op,
	input wire logic i_core_req,
	input wire logic [31:0] i_core_addr,
	input wire ctar_pkg::ctar_size_e i_core_size,
	input wire logic i_core_fetch,
	input wire logic i_prot_en,
	input wire logic i_dbg_req,
	input wire logic [31:0] i_dbg_addr,
	input wire ctar_pkg::ctar_size_e i_dbg_size,
	input wire logic i_hready,
	input wire logic o_issue_ready,
	input wire logic o_busy,
	input wire logic o_retire,
	input wire logic o_core_ready,
	input wire logic o_dbg_ready,
	input wire logic o_core_ack,
	input wire logic o_dbg_ack,
	input wire logic [1:0] o_htrans,
	input wire logic o_io_sel,
	input wire logic o_priv_sel,
	input wire logic o_size_fault,
	input wire logic o_hard_fault
);
	// ======================================================================
	// takes and address classes
	wire logic core_take = i_core_req && o_core_ready && i_hready;
	wire logic dbg_take = i_dbg_req && o_dbg_ready && i_hready && !core_take;
	wire logic core_priv = i_core_addr[31:28] == 4'he;
	wire logic dbg_priv = i_dbg_addr[31:28] == 4'he;
	wire logic core_code = i_core_addr[31:30] == 2'h0 || i_core_addr[31:29] == 3'h3
		|| i_core_addr[31:29] == 3'h4;
	wire logic issue_take = i_issue && o_issue_ready;

	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	// ======================================================================
	// matrix arbitration and routing
	core_wins_a: assert property (core_take && i_dbg_req && o_dbg_ready
		|=> o_core_ack && !o_dbg_ack) else $error("debug won over core");
	priv_inside_a: assert property (core_take && core_priv && !i_core_fetch
		&& i_core_size == CTAR_SZ_WORD |=> o_priv_sel && o_htrans == 2'h0)
		else $error("private access left the core");
	fetch_bus_a: assert property (core_take && i_core_fetch && core_code && !i_prot_en
		|=> o_htrans == 2'h2 && !o_io_sel) else $error("code fetch not on bus");
	io_redirect_a: assert property (IO_REDIRECT && core_take && !i_core_fetch
		&& !core_priv |=> o_io_sel && o_htrans == 2'h0) else $error("data not redirected");
	word_only_a: assert property (dbg_take && dbg_priv && i_dbg_size != CTAR_SZ_WORD
		|=> o_size_fault && !o_priv_sel) else $error("sub-word private access served");
	same_map_a: assert property (dbg_take && dbg_priv && i_dbg_size == CTAR_SZ_WORD
		|=> o_priv_sel && o_dbg_ack) else $error("debug private access misrouted");
	exec_never_a: assert property (core_take && i_core_fetch
		&& (core_priv || (!core_code && !i_prot_en)) |=> o_hard_fault && o_htrans == 2'h0)
		else $error("fetch from data region not faulted");

	// ======================================================================
	// fixed instruction figures
	single_cycle_a: assert property (issue_take && i_op inside {CTAR_OP_EXTEND,
		CTAR_OP_REVERSE, CTAR_OP_SEND_EVENT, CTAR_OP_NOP, CTAR_OP_YIELD}
		|=> o_busy ##1 (o_retire && !o_busy)) else $error("one-cycle op wrong length");
	three_cycle_a: assert property (issue_take && i_op inside {CTAR_OP_BRANCH_WITH_LINK,
		CTAR_OP_SPECIAL_REG_READ, CTAR_OP_SPECIAL_REG_WRITE, CTAR_OP_BARRIER}
		|=> o_busy [*3] ##1 (o_retire && !o_busy)) else $error("three-cycle op wrong length");
endmodule

bind ctar_core_timing ctar_core_timing_checker #(.IO_REDIRECT(IO_REDIRECT)) checker_i (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_issue(i_issue), .i_op(i_op),
	.i_core_req(i_core_req), .i_core_addr(i_core_addr), .i_core_size(i_core_size),
	.i_core_fetch(i_core_fetch), .i_prot_en(i_prot_en), .i_dbg_req(i_dbg_req),
	.i_dbg_addr(i_dbg_addr), .i_dbg_size(i_dbg_size), .i_hready(i_hready),
	.o_issue_ready(o_issue_ready), .o_busy(o_busy), .o_retire(o_retire),
	.o_core_ready(o_core_ready), .o_dbg_ready(o_dbg_ready), .o_core_ack(o_core_ack),
	.o_dbg_ack(o_dbg_ack), .o_htrans(o_htrans), .o_io_sel(o_io_sel),
	.o_priv_sel(o_priv_sel), .o_size_fault(o_size_fault), .o_hard_fault(o_hard_fault));

// ==== testbench/ctar_ahb_model.sv ====
// bus memory model that can add one wait state to each data phase
`timescale 1ns/100ps
module ctar_ahb_model
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [1:0] i_htrans,
	input wire logic i_slow,
	output logic o_hready
);
	// ======================================================================
	// wait state after every accepted address phase when slow
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_hready <= 1'b1;
		else
			o_hready <= !(i_slow && i_htrans == 2'h2 && o_hready);
	end
endmodule

// ==== testbench/ctar_core_timing_tb.sv ====
// self-checking bench for instruction timing and access routing
`timescale 1ns/100ps
module ctar_core_timing_tb;
	import ctar_pkg::*;
	localparam logic [5:0] SVC_C = 6'h05;
	localparam logic [5:0] BREAKPOINT_INSTR_C = 6'h07;
	logic i_clock, i_reset_n, i_issue, i_cond_pass, i_wake, i_hready, i_slow;
	logic i_core_req, i_core_write, i_core_fetch, i_prot_en, i_prot_xn, i_dbg_req, i_dbg_write;
	ctar_op_e i_op;
	ctar_size_e i_core_size, i_dbg_size;
	logic [3:0] i_reg_count;
	logic [31:0] i_store_addr, i_core_addr, i_core_wdata, i_dbg_addr, i_dbg_wdata;
	logic o_issue_ready, o_busy, o_retire, o_sleeping, o_core_ready, o_core_ack, o_dbg_ready;
	logic o_dbg_ack, o_hwrite, o_io_sel, o_priv_sel, o_local_write, o_size_fault, o_hard_fault;
	logic [5:0] o_last_cycles;
	logic [1:0] o_htrans;
	logic [2:0] o_hsize;
	logic [31:0] o_haddr, o_hwdata, o_local_addr, o_local_wdata;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;

	// ======================================================================
	// design with data redirected to the single-cycle port, and its bus
	ctar_core_timing #(.IO_REDIRECT(1'b1), .SVC_CYCLES(SVC_C), .BREAKPOINT_INSTR_CYCLES(BREAKPOINT_INSTR_C))
		ctar_core_timing_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_issue(i_issue),
		.i_op(i_op), .i_reg_count(i_reg_count), .i_cond_pass(i_cond_pass),
		.i_store_addr(i_store_addr), .i_wake(i_wake), .o_issue_ready(o_issue_ready),
		.o_busy(o_busy), .o_retire(o_retire), .o_sleeping(o_sleeping),
		.o_last_cycles(o_last_cycles), .i_core_req(i_core_req), .i_core_addr(i_core_addr),
		.i_core_write(i_core_write), .i_core_size(i_core_size), .i_core_fetch(i_core_fetch),
		.i_core_wdata(i_core_wdata), .i_prot_en(i_prot_en), .i_prot_xn(i_prot_xn),
		.o_core_ready(o_core_ready), .o_core_ack(o_core_ack), .i_dbg_req(i_dbg_req),
		.i_dbg_addr(i_dbg_addr), .i_dbg_write(i_dbg_write), .i_dbg_size(i_dbg_size),
		.i_dbg_wdata(i_dbg_wdata), .o_dbg_ready(o_dbg_ready), .o_dbg_ack(o_dbg_ack),
		.i_hready(i_hready), .o_haddr(o_haddr), .o_htrans(o_htrans), .o_hwrite(o_hwrite),
		.o_hsize(o_hsize), .o_hwdata(o_hwdata), .o_io_sel(o_io_sel), .o_priv_sel(o_priv_sel),
		.o_local_addr(o_local_addr), .o_local_write(o_local_write),
		.o_local_wdata(o_local_wdata), .o_size_fault(o_size_fault), .o_hard_fault(o_hard_fault));
	ctar_ahb_model ctar_ahb_model_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_htrans(o_htrans), .i_slow(i_slow), .o_hready(i_hready));

	// ======================================================================
	// clock and hang guard
	always #2 i_clock = ~i_clock;
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			fails++;
			report_and_stop;
		end
	end

	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok)
		begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	// expected figure per class, kept apart from the design's own tables
	function automatic logic [5:0] exp_cyc(input ctar_op_e op, input logic [3:0] n,
		input logic p, input logic [31:0] a);
		case (op)
			CTAR_OP_STORE_SINGLE: return (a[31:28] == 4'he) ? 6'h02 : 6'h01;
			CTAR_OP_STORE_MULTIPLE, CTAR_OP_PUSH, CTAR_OP_PUSH_LINK_REG,
			CTAR_OP_POP: return 6'h01 + 6'(n);
			CTAR_OP_POP_PROGRAM_COUNTER: return 6'h03 + 6'(n);
			CTAR_OP_BRANCH_COND: return p ? 6'h02 : 6'h01;
			CTAR_OP_BRANCH, CTAR_OP_BRANCH_EXCHANGE, CTAR_OP_BRANCH_LINK_EXCHANGE,
			CTAR_OP_WAIT_EVENT, CTAR_OP_WAIT_INTERRUPT: return 6'h02;
			CTAR_OP_BRANCH_WITH_LINK, CTAR_OP_SPECIAL_REG_READ, CTAR_OP_SPECIAL_REG_WRITE,
			CTAR_OP_BARRIER: return 6'h03;
			CTAR_OP_SUPERVISOR_CALL: return SVC_C;
			CTAR_OP_BREAKPOINT_INSTR: return BREAKPOINT_INSTR_C;
			default: return 6'h01;
		endcase
	endfunction

	// issue one op, count busy cycles, expect retire right after them
	task automatic run_op(input ctar_op_e op, input logic [3:0] n, input logic p,
		input logic [31:0] a, input logic [5:0] exp);
		int c;
		c = 0;
		while (o_issue_ready !== 1'b1 && c < 99)
		begin
			@(negedge i_clock);
			c++;
		end
		@(posedge i_clock);
		i_issue <= 1'b1;
		i_op <= op;
		i_reg_count <= n;
		i_cond_pass <= p;
		i_store_addr <= a;
		@(posedge i_clock);
		i_issue <= 1'b0;
		@(negedge i_clock);
		c = 0;
		while (o_busy === 1'b1 && c < 40)
		begin
			@(negedge i_clock);
			c++;
		end
		check(c == int'(exp) && o_retire === 1'b1 && o_last_cycles === exp, "cycle count");
	endtask

	// one matrix access; kind 0 bus, 1 io, 2 private, 3 size fault, 4 hard fault
	task automatic acc(input bit m, input logic [31:0] a, input bit f, input ctar_size_e s,
		input bit pe, input int kind);
		int c;
		@(posedge i_clock);
		i_core_addr <= a;
		i_dbg_addr <= a;
		i_core_size <= s;
		i_dbg_size <= s;
		i_core_fetch <= f;
		i_core_write <= !f;
		i_prot_en <= pe;
		i_prot_xn <= pe;
		i_core_req <= !m;
		i_dbg_req <= m;
		c = 0;
		@(negedge i_clock);
		while ((m ? o_dbg_ack : o_core_ack) !== 1'b1 && c < 20)
		begin
			@(negedge i_clock);
			c++;
		end
		check(o_htrans === (kind == 0 ? 2'h2 : 2'h0) && o_io_sel === (kind == 1)
			&& o_priv_sel === (kind == 2) && o_size_fault === (kind == 3)
			&& o_hard_fault === (kind == 4) && (kind != 0 || o_haddr === a)
			&& (kind != 0 || (o_hwrite === !f && o_hsize === {1'b0, s}))
			&& (kind != 2 || o_local_addr === a) && (kind == 0 || kind > 2
			|| (o_local_write === 1'b1 && o_local_wdata === (m ? i_dbg_wdata : i_core_wdata))),
			"routing");
		@(posedge i_clock);
		i_core_req <= 1'b0;
		i_dbg_req <= 1'b0;
		// write data follows one cycle after the address phase
		if (kind == 0)
		begin
			@(negedge i_clock);
			check(o_hwdata === i_core_wdata, "data phase");
		end
	endtask

	// core and debugger request in the same cycle
	task automatic contend;
		@(posedge i_clock);
		i_core_addr <= 32'h20000000;
		i_core_fetch <= 1'b0;
		i_core_size <= CTAR_SZ_WORD;
		i_dbg_addr <= 32'he0000010;
		i_dbg_size <= CTAR_SZ_WORD;
		i_core_req <= 1'b1;
		i_dbg_req <= 1'b1;
		repeat (2) @(negedge i_clock);
		check(o_core_ack === 1'b1 && o_dbg_ack === 1'b0 && o_io_sel === 1'b1, "core first");
		@(posedge i_clock);
		i_core_req <= 1'b0;
		@(negedge i_clock);
		check(o_dbg_ack === 1'b1 && o_priv_sel === 1'b1, "debug served next");
		@(posedge i_clock);
		i_dbg_req <= 1'b0;
	endtask

	// wait op stays asleep until woken
	task automatic sleep_wait;
		int c;
		@(posedge i_clock);
		i_wake <= 1'b0;
		run_op(CTAR_OP_WAIT_INTERRUPT, 4'h0, 1'b0, 32'h0, 6'h02);
		repeat (5) @(negedge i_clock);
		check(o_sleeping === 1'b1 && o_issue_ready === 1'b0, "sleep held");
		@(posedge i_clock);
		i_wake <= 1'b1;
		c = 0;
		@(negedge i_clock);
		while (o_sleeping === 1'b1 && c < 4)
		begin
			@(negedge i_clock);
			c++;
		end
		check(o_sleeping === 1'b0 && c < 3, "woken");
	endtask

	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ======================================================================
	// main sequence
	initial
	begin
		{i_clock, i_reset_n, i_issue, i_cond_pass, i_slow, i_core_req, i_dbg_req} = '0;
		{i_core_write, i_core_fetch, i_prot_en, i_prot_xn, i_reg_count} = '0;
		{i_store_addr, i_core_addr, i_core_wdata, i_dbg_addr} = '0;
		i_wake = 1'b1;
		i_dbg_write = 1'b1;
		i_dbg_wdata = 32'h5a5a0f0f;
		i_op = CTAR_OP_ALU;
		i_core_size = CTAR_SZ_WORD;
		i_dbg_size = CTAR_SZ_WORD;
		repeat (2) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(negedge i_clock);
		check(o_issue_ready === 1'b1 && o_core_ready === 1'b1 && o_dbg_ready === 1'b1
			&& o_htrans === 2'h0, "reset");
		for (int k = 0; k < 50; k++)
		begin
			i_core_wdata <= 32'(k);
			run_op(ctar_op_e'(k % 25), 4'(k * 7), k[1], k[0] ? 32'he0000000 : 32'h20000000,
				exp_cyc(ctar_op_e'(k % 25), 4'(k * 7), k[1], k[0] ? 32'he0000000 : 32'h20000000));
		end
		sleep_wait;
		for (int s = 0; s < 2; s++)
		begin
			i_slow <= s[0];
			acc(0, 32'h00000100, 1, CTAR_SZ_WORD, 0, 0);
			acc(0, 32'h9ffffffc, 1, CTAR_SZ_WORD, 0, 0);
			acc(0, 32'ha0000000, 1, CTAR_SZ_WORD, 0, 4);
			acc(0, 32'h40000000, 1, CTAR_SZ_WORD, 0, 4);
			acc(0, 32'he0000000, 1, CTAR_SZ_WORD, 1, 4);
			acc(0, 32'h60000000, 1, CTAR_SZ_WORD, 1, 4);
			acc(0, 32'hf0000000, 0, CTAR_SZ_WORD, 0, 1);
			acc(0, 32'hdffffffe, 0, CTAR_SZ_HALF, 0, 1);
			acc(0, 32'heffffffc, 0, CTAR_SZ_WORD, 0, 2);
			acc(0, 32'he0000000, 0, CTAR_SZ_BYTE, 0, 3);
			acc(1, 32'he000ed00, 0, CTAR_SZ_WORD, 0, 2);
			acc(1, 32'h20000000, 0, CTAR_SZ_WORD, 0, 1);
			acc(1, 32'he0000004, 0, CTAR_SZ_HALF, 0, 3);
			contend;
		end
		report_and_stop;
	end
endmodule
